// ### rtl/pssp_pkg.sv
package pssp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned STRETCH_TIME_MS = 40;
  localparam int unsigned STRETCH_CYCLES  = (CLK_HZ / 1000) * STRETCH_TIME_MS;
  localparam int unsigned STRETCH_W       = 22;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] REG_BMCR_IDX  = 8'h00;
  localparam logic [7:0] REG_PCS_IDX   = 8'h17;
  localparam logic [7:0] REG_LBR_IDX   = 8'h18;
  localparam logic [7:0] REG_TBS_IDX   = 8'h1b;
  localparam logic [7:0] REG_STRAP_IDX = 8'h1f;
  localparam int unsigned ADDR_W       = 12;

  // reset values
  localparam logic [15:0] BMCR_RESET = 16'h3000;
  localparam logic [15:0] PCS_RESET  = 16'h0080;
  localparam logic [15:0] LBR_RESET  = 16'h0000;
  localparam logic [15:0] TBS_RESET  = 16'h0000;

  // field positions
  localparam int unsigned BMCR_SPEED  = 13;
  localparam int unsigned BMCR_AN_EN  = 12;
  localparam int unsigned BMCR_PDOWN  = 11;
  localparam int unsigned BMCR_ISO    = 10;
  localparam int unsigned BMCR_FDX    = 8;
  localparam int unsigned PCS_PD_SEL  = 1;
  localparam int unsigned PCS_REFCK_N = 7;
  localparam int unsigned PCS_CL_SEL  = 11;
  localparam int unsigned PCS_REPEAT  = 12;
  localparam int unsigned LBR_CODER   = 14;
  localparam int unsigned LBR_SCR     = 13;
  localparam int unsigned LBR_ALIGN   = 12;
  localparam int unsigned TBS_SERIAL  = 9;

  // strap status register layout
  localparam int unsigned ST_PHYAD = 0;
  localparam int unsigned ST_TXM   = 5;
  localparam int unsigned ST_AN0   = 7;
  localparam int unsigned ST_AN1   = 9;
  localparam int unsigned ST_LPS   = 11;

  ////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [1:0] {
    LVL_LOW   = 2'b00,
    LVL_MID   = 2'b01,
    LVL_HIGH  = 2'b10,
    LVL_CLOCK = 2'b11
  } pssp_level_t;

  typedef enum logic [1:0] {
    MODE_NIBBLE = 2'b00,
    MODE_SYMBOL = 2'b01,
    MODE_SERIAL = 2'b10
  } pssp_if_mode_t;

  typedef enum logic [1:0] {
    PWR_RUN        = 2'b00,
    PWR_SOFT_DOWN  = 2'b01,
    PWR_PIN_DOWN   = 2'b10,
    PWR_START_DOWN = 2'b11
  } pssp_power_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        reset_pin;
    logic        loopback_request_pin;
    logic        power_down_pin;
    logic        mdc_pin;
    logic        serial_mode_strap;
    logic        coder_bypass_strap;
    logic        alignment_bypass_strap;
    logic        scrambler_bypass_strap;
    logic        isolate_default_strap;
    logic        repeater_strap;
    logic        low_power_start_strap_n;
    pssp_level_t tx_clock_mode_strap;
    pssp_level_t negotiation_strap_1;
    pssp_level_t negotiation_strap_0;
    logic [4:0]  phy_address_strap;
  } pssp_pins_t;

  typedef struct packed {
    logic an_en;
    logic speed100;
    logic fdx;
  } pssp_an_t;

  // negotiation strap pair decode: {auto, 100 Mb/s, full}
  function automatic pssp_an_t pssp_an_decode(input pssp_level_t an1, input pssp_level_t an0);
    pssp_an_t r;
    r = '{an_en: 1'b1, speed100: 1'b1, fdx: 1'b1};
    case ({an1, an0})
      {LVL_LOW,   LVL_MID}:   r = '{1'b0, 1'b0, 1'b0};
      {LVL_HIGH,  LVL_MID}:   r = '{1'b0, 1'b0, 1'b1};
      {LVL_MID,   LVL_LOW}:   r = '{1'b0, 1'b1, 1'b0};
      {LVL_MID,   LVL_HIGH}:  r = '{1'b0, 1'b1, 1'b1};
      {LVL_CLOCK, LVL_MID}:   r = '{1'b0, 1'b1, 1'b1};
      {LVL_MID,   LVL_CLOCK}: r = '{1'b0, 1'b1, 1'b1};
      {LVL_CLOCK, LVL_CLOCK}: r = '{1'b0, 1'b1, 1'b0};
      {LVL_LOW,   LVL_LOW}:   r = '{1'b1, 1'b0, 1'b0};
      {LVL_LOW,   LVL_HIGH}:  r = '{1'b1, 1'b0, 1'b1};
      {LVL_HIGH,  LVL_LOW}:   r = '{1'b1, 1'b1, 1'b0};
      {LVL_CLOCK, LVL_HIGH}:  r = '{1'b1, 1'b1, 1'b1};
      {LVL_CLOCK, LVL_LOW}:   r = '{1'b1, 1'b1, 1'b0};
      {LVL_HIGH,  LVL_CLOCK}: r = '{1'b1, 1'b1, 1'b1};
      {LVL_LOW,   LVL_CLOCK}: r = '{1'b1, 1'b0, 1'b1};
      default:                r = '{1'b1, 1'b1, 1'b1};
    endcase
    return r;
  endfunction

endpackage

// ### rtl/pssp_stretch.sv
`timescale 1ns/10ps
module pssp_stretch #(
  parameter int unsigned CYCLES = pssp_pkg::STRETCH_CYCLES,
  parameter int unsigned W      = pssp_pkg::STRETCH_W
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // event in, stretched level out
  input  wire logic trigger,
  output logic      active
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         active;
  } pssp_stretch_state_t;

  pssp_stretch_state_t state;
  pssp_stretch_state_t next_state;

  //////////////////////////////////////////////////////////////////////////////
  // retriggerable hold counter
  always_comb begin
    next_state = state;
    if (trigger) begin
      next_state.count = W'(CYCLES - 1);
    end else if (state.count != '0) begin
      next_state.count = state.count - W'(1);
    end
    next_state.active = trigger | (state.count != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active = state.active;

endmodule

// ### rtl/pssp_top.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
module pssp_top #(
  parameter int unsigned STRETCH_CYCLES = pssp_pkg::STRETCH_CYCLES
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pssp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // board pins and straps, asynchronous
  input  wire pssp_pkg::pssp_pins_t       board_pins,
  // status from the datapath, same clock
  input  wire logic                       rx_activity,
  input  wire logic                       tx_activity,
  input  wire logic                       collision,
  input  wire logic                       descrambler_locked,
  input  wire logic                       good_polarity,
  input  wire logic                       an_speed100,
  input  wire logic                       an_full_duplex,
  // open-drain indicators
  output logic                            polarity_duplex_indicator_o,
  output logic                            polarity_duplex_indicator_oe,
  output logic                            collision_lock_indicator_o,
  output logic                            collision_lock_indicator_oe,
  // speed indicators
  output logic                            slow_speed_indicator,
  output logic                            fast_speed_indicator,
  // reference clock tristate output
  output logic                            reference_clock_output_o,
  output logic                            reference_clock_output_oe,
  // mode and control to the datapath
  output logic                            tx_clock_is_output,
  output logic                            carrier_sense,
  output logic                            pmd_loopback,
  output logic                            endec_loopback,
  output pssp_pkg::pssp_if_mode_t         interface_mode,
  output pssp_pkg::pssp_power_t           power_state,
  output logic                            circuits_enabled,
  output logic                            mii_isolate,
  output logic                            coder_bypass,
  output logic                            alignment_bypass,
  output logic                            scrambler_bypass,
  output logic                            device_in_reset
);

  typedef struct packed {
    pssp_pkg::pssp_pins_t    sync1;
    pssp_pkg::pssp_pins_t    sync2;
    logic                    mdc_prev;
    logic [15:0]             bmcr;
    logic [15:0]             pcs;
    logic [15:0]             lbr;
    logic [15:0]             tbs;
    pssp_pkg::pssp_level_t   txm;
    pssp_pkg::pssp_level_t   an1;
    pssp_pkg::pssp_level_t   an0;
    logic [4:0]              phyad;
    logic                    low_power;
    logic [31:0]             prdata;
    logic                    refclk;
    logic                    refclk_en;
    logic                    txclk_out;
    logic                    pd_led;
    logic                    col_led;
    logic                    sp_10;
    logic                    sp_100;
    logic                    crs;
    logic                    pmd_lb;
    logic                    endec_lb;
    pssp_pkg::pssp_if_mode_t mode;
    pssp_pkg::pssp_power_t   power;
  } pssp_state_t;

  pssp_state_t state;
  pssp_state_t next_state;

  logic                    col_stretched;
  logic                    in_reset;
  logic                    speed100;
  logic                    fdx;
  logic                    mdc_toggle;
  logic                    hit;
  logic                    wr_en;
  logic [7:0]              reg_idx;
  logic [15:0]             rd_val;
  pssp_pkg::pssp_an_t      an_cfg;

  //////////////////////////////////////////////////////////////////////////////
  // collision event stretcher
  pssp_stretch #(
    .CYCLES (STRETCH_CYCLES),
    .W      (pssp_pkg::STRETCH_W)
  ) u_col_stretch (
    .pclk    (pclk),
    .presetn (presetn),
    .trigger (collision),
    .active  (col_stretched)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode
  assign in_reset   = state.sync2.reset_pin;
  assign mdc_toggle = state.sync2.mdc_pin ^ state.mdc_prev;
  assign reg_idx    = paddr[9:2];
  assign an_cfg     = pssp_pkg::pssp_an_decode(state.sync2.negotiation_strap_1,
                                               state.sync2.negotiation_strap_0);
  assign wr_en      = psel & penable & pwrite & hit & ~in_reset;

  always_comb begin
    hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
          ((reg_idx == pssp_pkg::REG_BMCR_IDX) || (reg_idx == pssp_pkg::REG_PCS_IDX) ||
           (reg_idx == pssp_pkg::REG_LBR_IDX) || (reg_idx == pssp_pkg::REG_TBS_IDX) ||
           (reg_idx == pssp_pkg::REG_STRAP_IDX));
  end

  always_comb begin
    rd_val = 16'h0000;
    case (reg_idx)
      pssp_pkg::REG_BMCR_IDX: rd_val = state.bmcr;
      pssp_pkg::REG_PCS_IDX:  rd_val = state.pcs;
      pssp_pkg::REG_LBR_IDX:  rd_val = state.lbr;
      pssp_pkg::REG_TBS_IDX:  rd_val = state.tbs;
      pssp_pkg::REG_STRAP_IDX: begin
        rd_val[pssp_pkg::ST_PHYAD +: 5] = state.phyad;
        rd_val[pssp_pkg::ST_TXM +: 2]   = state.txm;
        rd_val[pssp_pkg::ST_AN0 +: 2]   = state.an0;
        rd_val[pssp_pkg::ST_AN1 +: 2]   = state.an1;
        rd_val[pssp_pkg::ST_LPS]        = state.low_power;
      end
      default: rd_val = 16'h0000;
    endcase
  end

  // speed and duplex, forced or negotiated
  always_comb begin
    speed100 = state.bmcr[pssp_pkg::BMCR_AN_EN] ? an_speed100
                                                : state.bmcr[pssp_pkg::BMCR_SPEED];
    fdx      = state.bmcr[pssp_pkg::BMCR_AN_EN] ? an_full_duplex
                                                : state.bmcr[pssp_pkg::BMCR_FDX];
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state          = state;
    next_state.sync1    = board_pins;
    next_state.sync2    = state.sync1;
    next_state.mdc_prev = state.sync2.mdc_pin;

    // apb read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      next_state.prdata = hit ? {16'h0000, rd_val} : 32'h0;
    end

    if (in_reset) begin
      // initialize, then track straps until release
      next_state.bmcr = pssp_pkg::BMCR_RESET;
      next_state.pcs  = pssp_pkg::PCS_RESET;
      next_state.lbr  = pssp_pkg::LBR_RESET;
      next_state.tbs  = pssp_pkg::TBS_RESET;
      next_state.bmcr[pssp_pkg::BMCR_AN_EN] = an_cfg.an_en;
      next_state.bmcr[pssp_pkg::BMCR_SPEED] = an_cfg.speed100;
      next_state.bmcr[pssp_pkg::BMCR_FDX]   = an_cfg.fdx;
      next_state.bmcr[pssp_pkg::BMCR_ISO]   = state.sync2.isolate_default_strap;
      next_state.pcs[pssp_pkg::PCS_REPEAT]  = state.sync2.repeater_strap;
      next_state.lbr[pssp_pkg::LBR_CODER]   = state.sync2.coder_bypass_strap;
      next_state.lbr[pssp_pkg::LBR_ALIGN]   = state.sync2.alignment_bypass_strap;
      next_state.lbr[pssp_pkg::LBR_SCR]     = state.sync2.scrambler_bypass_strap;
      next_state.tbs[pssp_pkg::TBS_SERIAL]  = state.sync2.serial_mode_strap;
      next_state.phyad = state.sync2.phy_address_strap;
      next_state.txm   = state.sync2.tx_clock_mode_strap;
      next_state.an1   = state.sync2.negotiation_strap_1;
      next_state.an0   = state.sync2.negotiation_strap_0;
      next_state.low_power = ~state.sync2.low_power_start_strap_n;
    end else begin
      if (mdc_toggle) begin
        next_state.low_power = 1'b0;
      end
      if (wr_en) begin
        case (reg_idx)
          pssp_pkg::REG_BMCR_IDX: next_state.bmcr = pwdata[15:0];
          pssp_pkg::REG_PCS_IDX:  next_state.pcs  = pwdata[15:0];
          pssp_pkg::REG_LBR_IDX:  next_state.lbr  = pwdata[15:0];
          pssp_pkg::REG_TBS_IDX:  next_state.tbs  = pwdata[15:0];
          default: next_state.bmcr = state.bmcr;
        endcase
      end
    end

    // transmit clock direction and reference clock enable
    next_state.txclk_out = (state.txm == pssp_pkg::LVL_LOW);
    next_state.refclk_en = (state.txm == pssp_pkg::LVL_HIGH) |
                           ~state.pcs[pssp_pkg::PCS_REFCK_N];
    next_state.refclk    = next_state.refclk_en ? ~state.refclk : 1'b0;

    // interface mode
    if (state.tbs[pssp_pkg::TBS_SERIAL]) begin
      next_state.mode = pssp_pkg::MODE_SERIAL;
    end else if (state.lbr[pssp_pkg::LBR_ALIGN] || state.lbr[pssp_pkg::LBR_CODER]) begin
      next_state.mode = pssp_pkg::MODE_SYMBOL;
    end else begin
      next_state.mode = pssp_pkg::MODE_NIBBLE;
    end

    // power state, pin wins over start strap over software
    if (state.sync2.power_down_pin) begin
      next_state.power = pssp_pkg::PWR_PIN_DOWN;
    end else if (state.low_power) begin
      next_state.power = pssp_pkg::PWR_START_DOWN;
    end else if (state.bmcr[pssp_pkg::BMCR_PDOWN]) begin
      next_state.power = pssp_pkg::PWR_SOFT_DOWN;
    end else begin
      next_state.power = pssp_pkg::PWR_RUN;
    end

    // loopback
    next_state.pmd_lb   = state.sync2.loopback_request_pin & speed100;
    next_state.endec_lb = state.sync2.loopback_request_pin & ~speed100;

    // carrier sense
    if (state.pcs[pssp_pkg::PCS_REPEAT] || fdx) begin
      next_state.crs = rx_activity;
    end else begin
      next_state.crs = rx_activity | tx_activity;
    end

    // indicators, high means lamp on
    if (speed100) begin
      next_state.pd_led = fdx;
    end else begin
      next_state.pd_led = state.pcs[pssp_pkg::PCS_PD_SEL] ? fdx : good_polarity;
    end
    next_state.col_led = state.pcs[pssp_pkg::PCS_CL_SEL] ? descrambler_locked
                                                         : col_stretched;
    next_state.sp_10  = ~speed100;
    next_state.sp_100 = speed100;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= '0;
      state.bmcr   <= pssp_pkg::BMCR_RESET;
      state.pcs    <= pssp_pkg::PCS_RESET;
      state.lbr    <= pssp_pkg::LBR_RESET;
      state.tbs    <= pssp_pkg::TBS_RESET;
      state.txm    <= pssp_pkg::LVL_MID;
      state.an1    <= pssp_pkg::LVL_MID;
      state.an0    <= pssp_pkg::LVL_MID;
      state.mode   <= pssp_pkg::MODE_NIBBLE;
      state.power  <= pssp_pkg::PWR_RUN;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata  = state.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  assign polarity_duplex_indicator_o  = 1'b0;
  assign polarity_duplex_indicator_oe = state.pd_led;
  assign collision_lock_indicator_o   = 1'b0;
  assign collision_lock_indicator_oe  = state.col_led;
  assign slow_speed_indicator         = state.sp_10;
  assign fast_speed_indicator         = state.sp_100;
  assign reference_clock_output_o     = state.refclk;
  assign reference_clock_output_oe    = state.refclk_en;
  assign tx_clock_is_output           = state.txclk_out;
  assign carrier_sense                = state.crs;
  assign pmd_loopback                 = state.pmd_lb;
  assign endec_loopback               = state.endec_lb;
  assign interface_mode               = state.mode;
  assign power_state                  = state.power;
  assign circuits_enabled             = (state.power == pssp_pkg::PWR_RUN);
  assign mii_isolate                  = state.bmcr[pssp_pkg::BMCR_ISO];
  assign coder_bypass                 = state.lbr[pssp_pkg::LBR_CODER];
  assign alignment_bypass             = state.lbr[pssp_pkg::LBR_ALIGN];
  assign scrambler_bypass             = state.lbr[pssp_pkg::LBR_SCR];
  assign device_in_reset              = in_reset;

endmodule

// ### bench/pssp_properties.sv
`timescale 1ns/10ps
module pssp_properties (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // pins and status
  input wire pssp_pkg::pssp_pins_t  board_pins,
  input wire logic                  rx_activity,
  input wire logic                  tx_activity,
  // outputs watched
  input wire logic                  slow_speed_indicator,
  input wire logic                  fast_speed_indicator,
  input wire logic                  reference_clock_output_o,
  input wire logic                  reference_clock_output_oe,
  input wire logic                  carrier_sense,
  input wire logic                  pmd_loopback,
  input wire logic                  endec_loopback,
  input wire pssp_pkg::pssp_power_t power_state,
  input wire logic                  circuits_enabled,
  input wire logic                  device_in_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence refclk_run_s;
    reference_clock_output_oe [*2];
  endsequence
  sequence pin_held_s;
    (board_pins.power_down_pin && !device_in_reset) [*6];
  endsequence
  ////////////////////////////////////////
  err_in_access_a: assert property (
    pslverr |-> psel && penable && (pwrite || prdata == 32'h0))
    else $error("slave error outside access or with data");
  refclk_toggle_a: assert property (
    refclk_run_s |-> reference_clock_output_o != $past(reference_clock_output_o))
    else $error("reference clock not toggling");
  refclk_quiet_a: assert property (
    !reference_clock_output_oe |-> !reference_clock_output_o)
    else $error("reference clock active while tristated");
  speed_exclusive_a: assert property (
    !(slow_speed_indicator && fast_speed_indicator))
    else $error("both speed indicators high");
  power_run_tie_a: assert property (
    circuits_enabled |-> !$past(board_pins.power_down_pin, 3))
    else $error("circuits enabled while power pin held");
  pin_down_a: assert property (
    pin_held_s |-> power_state == pssp_pkg::PWR_PIN_DOWN)
    else $error("power pin held but not powered down");
  loopback_cause_a: assert property (
    pmd_loopback || endec_loopback |-> $past(board_pins.loopback_request_pin, 3))
    else $error("loopback without request");
  carrier_cause_a: assert property (
    carrier_sense |-> $past(rx_activity || tx_activity))
    else $error("carrier sense without activity");
  reset_sync_a: assert property (
    $past(presetn, 2) |-> device_in_reset == $past(board_pins.reset_pin, 2))
    else $error("device reset not following pin");
endmodule

bind pssp_top pssp_properties chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pslverr, .board_pins, .rx_activity, .tx_activity, .slow_speed_indicator,
  .fast_speed_indicator, .reference_clock_output_o, .reference_clock_output_oe,
  .carrier_sense, .pmd_loopback, .endec_loopback, .power_state, .circuits_enabled,
  .device_in_reset);

// ### bench/pssp_partner.sv
`timescale 1ns/10ps
module pssp_partner (
  // clock
  input  wire logic       pclk,
  // activity order: 0 idle, 1 receive, 2 transmit, 3 collision
  input  wire logic [1:0] cmd,
  // status toward the block
  output logic            rx_activity,
  output logic            tx_activity,
  output logic            collision
);
  initial begin
    rx_activity = 1'b0;
    tx_activity = 1'b0;
    collision   = 1'b0;
  end
  always @(posedge pclk) begin
    rx_activity <= (cmd == 2'h1);
    tx_activity <= cmd[1];
    collision   <= (cmd == 2'h3);
  end
endmodule

// ### bench/pssp_top_tb.sv
`timescale 1ns/10ps
module pssp_top_tb;
  localparam int unsigned STR = 16;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, r;
  pssp_pkg::pssp_pins_t    bp, s;
  logic [1:0]              cmd;
  logic                    descrambler_locked, good_polarity, an_speed100, an_full_duplex;
  logic                    rx_activity, tx_activity, collision;
  logic                    polarity_duplex_indicator_oe, collision_lock_indicator_oe;
  logic                    slow_speed_indicator, fast_speed_indicator;
  logic                    reference_clock_output_oe, tx_clock_is_output, carrier_sense;
  logic                    pmd_loopback, endec_loopback;
  pssp_pkg::pssp_if_mode_t interface_mode;
  pssp_pkg::pssp_power_t   power_state;
  int                      num_errors, checked, seed, n;
  logic [11:0]             adr [4] = '{12'h000, 12'h05c, 12'h060, 12'h06c};
  logic [15:0]             rv [4] = '{pssp_pkg::BMCR_RESET, pssp_pkg::PCS_RESET,
                                      pssp_pkg::LBR_RESET, pssp_pkg::TBS_RESET};
  logic [5:0]              row [3] = '{6'h21, 6'h16, 6'h05};
  ////////////////////////////////////////
  pssp_top #(.STRETCH_CYCLES(STR)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .board_pins(bp), .rx_activity, .tx_activity,
    .collision, .descrambler_locked, .good_polarity, .an_speed100, .an_full_duplex,
    .polarity_duplex_indicator_o(), .polarity_duplex_indicator_oe,
    .collision_lock_indicator_o(), .collision_lock_indicator_oe, .slow_speed_indicator,
    .fast_speed_indicator, .reference_clock_output_o(), .reference_clock_output_oe,
    .tx_clock_is_output, .carrier_sense, .pmd_loopback, .endec_loopback, .interface_mode,
    .power_state, .circuits_enabled(), .mii_isolate(), .coder_bypass(),
    .alignment_bypass(), .scrambler_bypass(), .device_in_reset());
  pssp_partner mac (.pclk, .cmd, .rx_activity, .tx_activity, .collision);
  always #10 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic chk(input string t, input logic [31:0] x, input logic [31:0] y);
    checked++;
    if (y !== x) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", t, x, y);
    end
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask
  task automatic dev_reset();
    bp.reset_pin <= 1'b1;
    tick(6);
    bp.reset_pin <= 1'b0;
    tick(8);
  endtask
  function automatic pssp_pkg::pssp_if_mode_t mode_f(input pssp_pkg::pssp_pins_t p);
    if (p.serial_mode_strap)
      return pssp_pkg::MODE_SERIAL;
    return (p.alignment_bypass_strap || p.coder_bypass_strap) ? pssp_pkg::MODE_SYMBOL
                                                                : pssp_pkg::MODE_NIBBLE;
  endfunction
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cmd} = '0;
    {descrambler_locked, good_polarity, an_speed100, an_full_duplex} = '0;
    bp = 22'h000aa8;
    seed = 32'h91c4;
    tick(6);
    presetn <= 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      rd(adr[i]);
      chk("reset_value", {16'h0, rv[i]}, r);
    end
    rd(12'h400);
    chk("slverr", 1'b1, e);
    chk("unmapped_data", 32'h0, r);
    done("registers");
    for (int i = 0; i < 3; i++) begin
      bp[17:12] <= 6'($random(seed));
      bp[4:0] <= 5'($random(seed));
      bp[10:5] <= row[i];
      an_speed100 <= 1'($random(seed));
      dev_reset();
      s = bp;
      bp <= bp ^ 22'h03f01f;
      tick(6);
      rd(12'h05c);
      chk("repeater", s.repeater_strap, r[12]);
      rd(12'h060);
      chk("coder", s.coder_bypass_strap, r[14]);
      chk("align", s.alignment_bypass_strap, r[12]);
      rd(12'h06c);
      chk("serial", s.serial_mode_strap, r[9]);
      rd(12'h07c);
      chk("phy_address", s.phy_address_strap, r[4:0]);
      rd(12'h000);
      chk("an_enable", i == 2, r[12]);
      chk("isolate", s.isolate_default_strap, r[10]);
      chk("mode", mode_f(s), interface_mode);
      chk("txclk_out", i == 2, tx_clock_is_output);
      chk("refclk_oe", i == 0, reference_clock_output_oe);
      chk("fast", (i == 2) ? an_speed100 : (i == 1), fast_speed_indicator);
    end
    done("straps");
    bp.low_power_start_strap_n <= 1'b0;
    dev_reset();
    bp.low_power_start_strap_n <= 1'b1;
    chk("lp_start", pssp_pkg::PWR_START_DOWN, power_state);
    bp.mdc_pin <= 1'b1;
    tick(6);
    chk("lp_exit", pssp_pkg::PWR_RUN, power_state);
    bp.power_down_pin <= 1'b1;
    tick(6);
    chk("pin_down", pssp_pkg::PWR_PIN_DOWN, power_state);
    bp.power_down_pin <= 1'b0;
    tick(6);
    chk("pin_up", pssp_pkg::PWR_RUN, power_state);
    wr(12'h000, 16'h0800);
    tick(3);
    chk("soft_down", pssp_pkg::PWR_SOFT_DOWN, power_state);
    chk("slow", 1'b1, slow_speed_indicator);
    done("power");
    for (int k = 0; k < 4; k++) begin
      good_polarity <= 1'($random(seed));
      wr(12'h000, {2'b0, k[1], 4'h0, k[0], 8'h0});
      wr(12'h05c, 16'h0080);
      bp.loopback_request_pin <= 1'b1;
      cmd <= 2'h2;
      tick(6);
      chk("pmd_loop", k[1], pmd_loopback);
      chk("endec_loop", !k[1], endec_loopback);
      chk("crs_tx", !k[0], carrier_sense);
      chk("dup_lamp", k[1] ? k[0] : good_polarity, polarity_duplex_indicator_oe);
      wr(12'h05c, 16'h1082);
      tick(3);
      chk("crs_repeater", 1'b0, carrier_sense);
      chk("dup_select", k[0], polarity_duplex_indicator_oe);
      bp.loopback_request_pin <= 1'b0;
      cmd <= 2'h0;
    end
    done("loopback");
    wr(12'h05c, 16'h0080);
    cmd <= 2'h3;
    tick(1);
    cmd <= 2'h0;
    tick(5);
    chk("col_on", 1'b1, collision_lock_indicator_oe);
    n = 0;
    while (collision_lock_indicator_oe === 1'b1 && n < 60) begin
      n++;
      tick(1);
    end
    chk("stretch", 1'b1, n >= STR - 6 && n <= STR + 2);
    wr(12'h05c, 16'h0880);
    descrambler_locked <= 1'b1;
    tick(4);
    chk("lock_on", 1'b1, collision_lock_indicator_oe);
    wr(12'h05c, 16'h0000);
    tick(3);
    chk("refclk_force", 1'b1, reference_clock_output_oe);
    tick(8);
    done("indicators");
    summarize();
  end
endmodule
